// ---- common/dmsd_pkg.sv ----
// Constants and types shared by the swallow divider and its serial loader.
// Assumes a single 100 MHz system clock samples all pins.
package dmsd_pkg;
  // Field widths of the counter latches
  localparam int SW_W = 7;
  localparam int MAIN_W = 10;
  localparam int REF_W = 11;
  // Serial word: swallow is last in, then main, then reference
  localparam int SW_LSB = 0;
  localparam int MAIN_LSB = SW_LSB + SW_W;
  localparam int REF_LSB = MAIN_LSB + MAIN_W;
  localparam int WORD_W = REF_LSB + REF_W;
  // Falling programming-clock edges that mark a full word
  localparam logic [4:0] FULL_EDGES = 5'h1c;
  localparam logic [4:0] EDGE_CNT_RST = 5'h00;
  // Latch values after reset
  localparam logic [SW_W-1:0] SW_RST = 7'h00;
  localparam logic [MAIN_W-1:0] MAIN_RST = 10'h003;
  localparam logic [MAIN_W-1:0] MAIN_ONE = 10'h001;
  localparam logic [SW_W-1:0] SW_ONE = 7'h01;
  localparam logic [REF_W-1:0] REF_RST = 11'h003;
  localparam logic [WORD_W-1:0] WORD_RST = 28'h0000000;

  typedef struct packed {
    logic [MAIN_W-1:0] main_val;
    logic [SW_W-1:0] swallow_val;
  } dmsd_ratio_t;

  localparam dmsd_ratio_t RATIO_RST = '{main_val: MAIN_RST, swallow_val: SW_RST};

  // Modulus phase: low while swallowing, high for the rest of the main count
  typedef enum logic [0:0] {
    PH_SWALLOW = 1'h0,
    PH_MAIN = 1'h1
  } dmsd_phase_t;
endpackage

// ---- rtl/dmsd_loader.sv ----
// Serial input shift register and counter latches of the divider.
// Inputs are already synchronised to clk by the parent.
`timescale 1ns/1ps
`default_nettype none
module dmsd_loader import dmsd_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Synchronised programming pins
  input wire logic en_s,
  input wire logic sclk_s,
  input wire logic sdat_s,
  // Latched ratios
  output dmsd_ratio_t ratio,
  output logic [REF_W-1:0] ref_ratio,
  output logic load_pulse
);
  logic en_prev_r, en_prev_nxt;
  logic sclk_prev_r, sclk_prev_nxt;
  logic [WORD_W-1:0] sr_r, sr_nxt;
  logic [4:0] edges_r, edges_nxt;
  dmsd_ratio_t ratio_r, ratio_nxt;
  logic [REF_W-1:0] ref_r, ref_nxt;
  logic load_r, load_nxt;
  logic en_fall;

  assign en_fall = en_prev_r & ~en_s;

  always_comb begin
    en_prev_nxt = en_s;
    sclk_prev_nxt = sclk_s;
    sr_nxt = sr_r;
    edges_nxt = edges_r;
    ratio_nxt = ratio_r;
    ref_nxt = ref_r;
    load_nxt = 1'b0;
    if (en_s & ~en_prev_r) begin
      edges_nxt = EDGE_CNT_RST;
    end
    if (en_s) begin
      if (sclk_s & ~sclk_prev_r) begin
        sr_nxt = {sr_r[WORD_W-2:0], sdat_s};
      end
      if (~sclk_s & sclk_prev_r & (edges_r != FULL_EDGES)) begin
        edges_nxt = edges_r + 5'h01;
      end
    end
    if (en_fall) begin
      ratio_nxt.main_val = sr_r[MAIN_LSB +: MAIN_W];
      ratio_nxt.swallow_val = sr_r[SW_LSB +: SW_W];
      load_nxt = 1'b1;
      // reference only after a full word
      if (edges_r == FULL_EDGES) begin
        ref_nxt = sr_r[REF_LSB +: REF_W];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en_prev_r <= 1'b0;
      sclk_prev_r <= 1'b1;
      sr_r <= WORD_RST;
      edges_r <= EDGE_CNT_RST;
      ratio_r <= RATIO_RST;
      ref_r <= REF_RST;
      load_r <= 1'b0;
    end else begin
      en_prev_r <= en_prev_nxt;
      sclk_prev_r <= sclk_prev_nxt;
      sr_r <= sr_nxt;
      edges_r <= edges_nxt;
      ratio_r <= ratio_nxt;
      ref_r <= ref_nxt;
      load_r <= load_nxt;
    end
  end

  assign ratio = ratio_r;
  assign ref_ratio = ref_r;
  assign load_pulse = load_r;

  a_shift_ignored_low: assert property (@(posedge clk) disable iff (!arst_n)
    !en_s |=> sr_r == $past(sr_r)) else $error("shift register moved while disabled");
  a_latch_on_fall: assert property (@(posedge clk) disable iff (!arst_n)
    en_fall |=> load_r && ratio_r.swallow_val == $past(sr_r[SW_LSB +: SW_W]))
    else $error("latch not loaded on enable fall");
  a_ref_guarded: assert property (@(posedge clk) disable iff (!arst_n)
    ref_r != $past(ref_r) |-> $past(en_fall) && $past(edges_r) == FULL_EDGES)
    else $error("reference latch changed without full word");
  a_ratio_stable: assert property (@(posedge clk) disable iff (!arst_n)
    !$past(en_fall) |-> ratio_r == $past(ratio_r)) else $error("ratio changed outside load");
endmodule
`default_nettype wire

// ---- rtl/dmsd_top.sv ----
// Dual-modulus swallow divider with serial ratio loading.
// Assumes prescaler output and programming pins are asynchronous to clk,
// and that the prescaler output is much slower than clk.
// What this block does
// - Modulus select goes low at the start of each count cycle with a nonzero swallow value and stays low until the swallow count is done.
// - After the swallow count, modulus select is high until the main count is done.
// - Completing the main count resets both counters together and starts a new cycle.
// - With the prescaler switching N and N+1, the chain divides by main times N plus swallow.
// - The swallow value is a seven-bit field covering 0 to 127.
// - The scheme serves prescalers up to a 128/129 pair.
// - The main value is a ten-bit field covering 3 to 1023.
// - While enable is high, serial data is shifted in on the programming clock.
// - On enable falling, the shift register contents go to the counter latches.
// - While enable is low, data and programming clock are ignored.
// - On enable falling, the phase detector inputs are resynchronised.
// - The reference latch loads only after 28 falling clock edges; otherwise only main and swallow move.
`timescale 1ns/1ps
`default_nettype none
module dmsd_top import dmsd_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Prescaler side
  input wire logic prescaler_in,
  output logic modulus_select_out,
  // Programming pins
  input wire logic ser_data,
  input wire logic ser_clk,
  input wire logic ser_enable,
  // Toward the phase comparator and reference chain
  output logic cmp_pulse,
  output logic pd_resync,
  output logic [REF_W-1:0] ref_ratio
);
  // Limit test shared by both counters
  function automatic logic at_limit(input logic [MAIN_W-1:0] cnt, input logic [MAIN_W-1:0] lim);
    at_limit = (cnt >= lim);
  endfunction

  logic [3:0] sync1_r, sync2_r;
  logic pre_prev_r, pre_prev_nxt;
  logic pre_rise;
  // counters as wide as their fields
  logic [MAIN_W-1:0] main_r, main_nxt;
  logic [SW_W-1:0] sw_r, sw_nxt;
  dmsd_phase_t phase_r, phase_nxt;
  logic pulse_r, pulse_nxt;
  logic resync_r, resync_nxt;
  dmsd_ratio_t ratio;
  logic load_pulse;
  logic main_done;
  logic [REF_W-1:0] ref_w;
  logic [MAIN_W-1:0] sw_wide_nxt;

  // Two-stage synchronisers; only stage two is read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end else begin
      sync1_r <= {ser_enable, ser_clk, ser_data, prescaler_in};
      sync2_r <= sync1_r;
    end
  end

  dmsd_loader u_loader (
    .clk(clk),
    .arst_n(arst_n),
    .en_s(sync2_r[3]),
    .sclk_s(sync2_r[2]),
    .sdat_s(sync2_r[1]),
    .ratio(ratio),
    .ref_ratio(ref_w),
    .load_pulse(load_pulse)
  );

  assign pre_rise = sync2_r[0] & ~pre_prev_r;
  // Main value below one would never terminate; treat as one
  assign main_done = at_limit(main_r + MAIN_ONE, ratio.main_val);

  always_comb begin
    pre_prev_nxt = sync2_r[0];
    main_nxt = main_r;
    sw_nxt = sw_r;
    pulse_nxt = 1'b0;
    resync_nxt = 1'b0;
    if (load_pulse) begin
      // restart both sides after a new load
      main_nxt = '0;
      sw_nxt = '0;
      resync_nxt = 1'b1;
    end else if (pre_rise) begin
      if (main_done) begin
        main_nxt = '0;
        sw_nxt = '0;
        pulse_nxt = 1'b1;
      end else begin
        main_nxt = main_r + MAIN_ONE;
        if (sw_r < ratio.swallow_val) begin
          sw_nxt = sw_r + SW_ONE;
        end
      end
    end
    sw_wide_nxt = {{(MAIN_W-SW_W){1'b0}}, sw_nxt};
    // modulus phase follows the swallow count
    if (at_limit(sw_wide_nxt, {{(MAIN_W-SW_W){1'b0}}, ratio.swallow_val})) begin
      phase_nxt = PH_MAIN;
    end else begin
      phase_nxt = PH_SWALLOW;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_prev_r <= 1'b0;
      main_r <= '0;
      sw_r <= SW_RST;
      phase_r <= PH_MAIN;
      pulse_r <= 1'b0;
      resync_r <= 1'b0;
    end else begin
      pre_prev_r <= pre_prev_nxt;
      main_r <= main_nxt;
      sw_r <= sw_nxt;
      phase_r <= phase_nxt;
      pulse_r <= pulse_nxt;
      resync_r <= resync_nxt;
    end
  end

  logic [REF_W-1:0] ref_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_r <= REF_RST;
    end else begin
      ref_r <= ref_w;
    end
  end

  // swallow span reaches a 128/129 pair
  assign modulus_select_out = phase_r[0];
  assign cmp_pulse = pulse_r;
  assign pd_resync = resync_r;
  assign ref_ratio = ref_r;

  a_mod_low_start: assert property (@(posedge clk) disable iff (!arst_n)
    (pulse_nxt && ratio.swallow_val != SW_RST && !load_pulse) |=> !modulus_select_out)
    else $error("modulus select not low at cycle start");
  a_mod_high_after: assert property (@(posedge clk) disable iff (!arst_n)
    sw_r == ratio.swallow_val && main_r != '0 |-> modulus_select_out)
    else $error("modulus select low after swallow done");
  a_cycle_reset: assert property (@(posedge clk) disable iff (!arst_n)
    pulse_r |-> main_r == '0 && sw_r == SW_RST) else $error("counters not reset together");
  a_pulse_on_wrap: assert property (@(posedge clk) disable iff (!arst_n)
    pre_rise && main_done && !load_pulse |=> cmp_pulse ##1 !cmp_pulse)
    else $error("comparator pulse missing or long");
  a_sw_bounded: assert property (@(posedge clk) disable iff (!arst_n)
    sw_r <= ratio.swallow_val || load_pulse || $past(load_pulse)) else $error("swallow overran its value");
  a_resync_load: assert property (@(posedge clk) disable iff (!arst_n)
    load_pulse |=> pd_resync && main_r == '0) else $error("no resync on load");
  a_main_holds: assert property (@(posedge clk) disable iff (!arst_n)
    !pre_rise && !load_pulse |=> main_r == $past(main_r)) else $error("main count moved without edge");
  a_mod_follows: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(modulus_select_out) |-> $past(sw_nxt) == ratio.swallow_val || $past(load_pulse))
    else $error("modulus rose before swallow done");
endmodule
`default_nettype wire

// ---- bench/dmsd_partner.sv ----
// Prescaler and serial programming controller model for the divider.
// Assumes clk is the divider's clock; pins move just after its rising edge.
`timescale 1ns/1ps
`default_nettype none
module dmsd_partner (
  // Clock
  input wire logic clk,
  // Pins toward the divider
  output logic prescaler_in,
  output logic ser_data,
  output logic ser_clk,
  output logic ser_enable,
  // Divider feedback
  input wire logic modulus_select_out,
  input wire logic cmp_pulse
);
  initial begin
    prescaler_in = 1'b0;
    ser_data = 1'b0;
    ser_clk = 1'b1;
    ser_enable = 1'b0;
  end
  // One prescaler period, 4 clk high and 5 low; sel is the modulus in force
  task automatic pulse(output logic sel, output logic done);
    sel = modulus_select_out;
    done = 1'b0;
    @(posedge clk) prescaler_in <= 1'b1;
    for (int i = 1; i <= 8; i++) begin
      // Look at the one-cycle pulse away from the edge that launches it
      @(negedge clk);
      if (cmp_pulse === 1'b1) done = 1'b1;
      @(posedge clk);
      if (i == 4) prescaler_in <= 1'b0;
    end
  endtask
  task automatic load(input logic [27:0] word, input int nbits);
    @(posedge clk) ser_enable <= 1'b1;
    for (int i = nbits - 1; i >= 0; i--) begin
      repeat (4) @(posedge clk);
      ser_data <= word[i];
      ser_clk <= 1'b0;
      repeat (4) @(posedge clk);
      ser_clk <= 1'b1;
    end
    repeat (4) @(posedge clk);
    ser_enable <= 1'b0;
    // Released data line must not keep its last level
    ser_data <= ~word[0];
  endtask
  // Pin noise while disabled, ending with ser_clk high
  task automatic junk();
    repeat (6) begin
      repeat (4) @(posedge clk);
      ser_clk <= ~ser_clk;
      ser_data <= ~ser_data;
    end
  endtask
endmodule
`default_nettype wire

// ---- bench/dmsd_tb_top.sv ----
// Self-checking bench for the swallow divider top.
// Assumes the partner model drives every prescaler and programming pin.
`timescale 1ns/1ps
`default_nettype none
module dual_modulus_swallow_divider_tb_top import dmsd_pkg::*; ;
  logic clk, arst_n, prescaler_in, modulus_select_out, ser_data, ser_clk, ser_enable;
  logic cmp_pulse, pd_resync;
  logic [REF_W-1:0] ref_ratio;
  int errors = 0;
  int compares = 0;

  initial clk = 1'b0;
  always #5 clk = ~clk;

  dmsd_top u_dut (.clk(clk), .arst_n(arst_n), .prescaler_in(prescaler_in),
    .modulus_select_out(modulus_select_out), .ser_data(ser_data), .ser_clk(ser_clk),
    .ser_enable(ser_enable), .cmp_pulse(cmp_pulse), .pd_resync(pd_resync), .ref_ratio(ref_ratio));
  dmsd_partner u_partner (.clk(clk), .prescaler_in(prescaler_in), .ser_data(ser_data),
    .ser_clk(ser_clk), .ser_enable(ser_enable), .modulus_select_out(modulus_select_out),
    .cmp_pulse(cmp_pulse));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One whole count cycle: m pulses, a of them with select low
  task automatic run_cycle(input int m, input int a, input int n);
    logic sel, done;
    int pulses, lows, vco;
    pulses = 0;
    lows = 0;
    vco = 0;
    done = 1'b0;
    while (!done && pulses < 1100) begin
      u_partner.pulse(sel, done);
      pulses++;
      lows += (sel === 1'b0);
      vco += (sel === 1'b0) ? n + 1 : n;
    end
    check(pulses, m);
    check(lows, a);
    check(vco, m * n + a);
  endtask

  task automatic load_ratio(input logic [10:0] rv, input logic [9:0] m, input logic [6:0] a,
                            input int nbits, input logic [10:0] exp_ref);
    int t;
    u_partner.load({rv, m, a}, nbits);
    t = 0;
    while (pd_resync !== 1'b1 && t < 12) begin
      @(negedge clk);
      t++;
    end
    check(t < 12, 1);
    check(ref_ratio, exp_ref);
  endtask

  task automatic scen_reset();
    check(modulus_select_out, 1'b1);
    check(cmp_pulse, 1'b0);
    check(pd_resync, 1'b0);
    check(ref_ratio, REF_RST);
    run_cycle(3, 0, 8);
  endtask

  task automatic scen_full();
    load_ratio(11'h190, 10'h014, 7'h05, 28, 11'h190);
    run_cycle(20, 5, 8);
    run_cycle(20, 5, 8);
  endtask

  task automatic scen_ignore();
    u_partner.junk();
    run_cycle(20, 5, 8);
    check(ref_ratio, 11'h190);
  endtask

  // Short word: only main and swallow move, N of 4 keeps the ratio usable
  task automatic scen_short();
    load_ratio(11'h000, 10'h003, 7'h03, 17, 11'h190);
    run_cycle(3, 3, 4);
  endtask

  task automatic scen_bounds();
    load_ratio(11'h005, 10'h3ff, 7'h7f, 28, 11'h005);
    run_cycle(1023, 127, 128);
  endtask

  initial begin
    arst_n = 1'b0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(negedge clk);
    scen_reset();
    scen_full();
    scen_ignore();
    scen_short();
    scen_bounds();
    end_of_test();
  end

  // Run needs about 10500 cycles; cut a hang well past that
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
